// *** shared/frg_consts.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef FRG_CONSTS_SVH
`define FRG_CONSTS_SVH
`define FRG_ADDR_W 4
`define FRG_NUM_REGS 11
`define FRG_REG_READBACK 4'hf
`define FRG_N_INT_LSB 4
`define FRG_N_FRAC_LSB 12
`define FRG_TX_RX_BIT 27
`define FRG_LPF_BW_LSB 22
`define FRG_PA_EN_BIT 4
`define FRG_MOD_SEL_LSB 6
`define FRG_PA_PWR_LSB 9
`define FRG_MOD_NUM_LSB 15
`define FRG_PA_BIAS_LSB 30
`define FRG_MOD_FSK 3'h0
`define FRG_OS_DIV_LSB 4
`define FRG_SEQ_DIV_LSB 18
`define FRG_LNA_NOISE_POWER_SELECT_BIT 15
`define FRG_MIXER_BIT 18
`define FRG_CAL_START_BIT 19
`define FRG_CAL_DIV_LSB 20
`define FRG_AGC_LOW_LSB 4
`define FRG_AGC_HIGH_LSB 11
`define FRG_AGC_AUTO_A_BIT 18
`define FRG_AGC_AUTO_B_BIT 19
`define FRG_STEP_A_LSB 20
`define FRG_FG_MAN_LSB 22
`define FRG_SETTLE_LSB 4
`define FRG_RST_R2 32'h4000_0000
`define FRG_RST_R3 32'h00c8_0000
`define FRG_RST_R9 32'h00b2_31e0
`define FRG_RST_R10 32'h0000_00a0
`define FRG_GAIN_TOP 3'h5
`define FRG_RSSI_LEVELS 80
`define FRG_CLK_PERIOD_NS 5
`define FRG_CAL_TIME_NS 200000
`define FRG_CAL_CYCLES (`FRG_CAL_TIME_NS / `FRG_CLK_PERIOD_NS)
`endif

// *** shared/frg_pkg.sv ***
// Types shared by the radio gain control block.
package frg_pkg;
  typedef enum logic [0:0] {FRG_AGC_TRACK, FRG_AGC_SETTLE} frg_agc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } frg_bus_t;

  typedef struct packed {
    logic pa_enable;
    logic [5:0] pa_power;
    logic [1:0] pa_bias;
    logic [2:0] mod_select;
    logic lna_short_switch;
    logic lna_noise_power_select;
    logic mixer_current_linearity_select;
    logic [1:0] step_a;
    logic [1:0] channel_filter_gain_step;
    logic [1:0] lpf_bandwidth;
    logic [8:0] lpf_cal_divider;
  } frg_rf_ctrl_t;

  typedef struct packed {
    logic [10:0][31:0] regs;
    logic [31:0] rdata;
    logic [15:0] cal_cnt;
    logic cal_busy;
    frg_agc_state_t agc;
    logic [2:0] gain_idx;
    logic [15:0] wait_cnt;
    logic [6:0] rssi;
    logic [22:0] divider;
    logic [3:0] os_cnt;
    logic os_clk;
  } frg_state_t;
endpackage

// *** logic/frg_gain_control.sv ***
// Digital control core of the FSK transceiver: keying, front end, AGC.
// Behaviour
// - Transmit keys divider between centre and deviated values.
// - Deviation is PFD times modulation number over 2^14.
// - Modulation field selects scheme; one code is FSK.
// - Output power field, independent of data pin.
// - Two-bit field sets amplifier bias current.
// - Clear bit powers down transmit output stage.
// - Transmit selection closes short switch across LNA.
// - One bit picks LNA noise or power mode.
// - One bit picks mixer current or linearity mode.
// - Step_a from user or gain loop.
// - Two bits choose filter bandwidth 300/450/600 kHz.
// - Start bit runs self-timed 200 us calibration.
// - Filter gain manual three levels, else automatic.
// - RSSI flash converted to 80 levels, seven bits.
// - Offset clock is crystal divided by 4/8/16.
// - Gain loop active when both auto bits clear.
// - Low and high seven-bit gain thresholds.
// - Wait settle delay times sequencer divisor after change.
// - Gain codes reported in readback.
//
// Strobed register access and the address map are this design's own decisions.
`include "frg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module frg_gain_control #(
  parameter int CAL_CYCLES = `FRG_CAL_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_enable,
  input wire frg_pkg::frg_bus_t bus,
  output logic [31:0] rdata,
  input wire logic tx_data_line,
  input wire logic [`FRG_RSSI_LEVELS-2:0] rssi_comparators,
  output logic [22:0] synth_divider,
  output frg_pkg::frg_rf_ctrl_t rf_ctrl,
  output logic lpf_cal_busy,
  output logic agc_active,
  output logic baseband_offset_clock
);

  frg_pkg::frg_state_t s_r;
  frg_pkg::frg_state_t s_nxt;

  // Default register image; also loaded whenever the chip is disabled.
  function automatic logic [10:0][31:0] rst_regs();
    logic [10:0][31:0] r;
    r = '0;
    r[2] = `FRG_RST_R2;
    r[3] = `FRG_RST_R3;
    r[9] = `FRG_RST_R9;
    r[10] = `FRG_RST_R10;
    return r;
  endfunction

  // Counts tripped comparators of the thermometer-coded flash converter.
  function automatic logic [6:0] flash_code(
    input logic [`FRG_RSSI_LEVELS-2:0] t
  );
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < `FRG_RSSI_LEVELS - 1; i++) begin
      c = c + {6'h00, t[i]};
    end
    return c;
  endfunction

  // Gain ladder, lowest first: LNA code per step.
  function automatic logic [1:0] ladder_lna(input logic [2:0] idx);
    if (idx >= 3'h5) begin
      return 2'h3;
    end else if (idx >= 3'h2) begin
      return 2'h2;
    end else begin
      return idx[1:0];
    end
  endfunction

  // Gain ladder, lowest first: filter code per step.
  function automatic logic [1:0] ladder_fg(input logic [2:0] idx);
    if (idx >= 3'h4) begin
      return 2'h2;
    end else if (idx == 3'h3) begin
      return 2'h1;
    end else begin
      return 2'h0;
    end
  endfunction

  logic [31:0] r0, r2, r3, r6, r9, r10;
  logic [22:0] centre;
  logic [9:0] deviation;
  logic [8:0] mod_num;
  logic [6:0] thr_low, thr_high;
  logic [15:0] wait_load;
  logic [1:0] fg_manual;
  logic [1:0] lna_now, fg_now;
  logic [31:0] readback;

  // Field views of the live register image.
  assign r0 = s_r.regs[0];
  assign r2 = s_r.regs[2];
  assign r3 = s_r.regs[3];
  assign r6 = s_r.regs[6];
  assign r9 = s_r.regs[9];
  assign r10 = s_r.regs[10];
  assign centre = {r0[`FRG_N_INT_LSB +: 8], r0[`FRG_N_FRAC_LSB +: 15]};
  assign mod_num = r2[`FRG_MOD_NUM_LSB +: 9];
  // Fraction is in 2^-15 units, so doubling gives the 2^-14 step.
  assign deviation = (mod_num == 9'h000) ? 10'h002 : {mod_num, 1'b0};
  assign thr_low = r9[`FRG_AGC_LOW_LSB +: 7];
  assign thr_high = r9[`FRG_AGC_HIGH_LSB +: 7];
  // Auto is the cleared setting of both mode bits.
  assign agc_active = !r9[`FRG_AGC_AUTO_A_BIT] && !r9[`FRG_AGC_AUTO_B_BIT];
  // A zero product would stall nothing, so at least one cycle is waited.
  always_comb begin
    wait_load = 16'(r10[`FRG_SETTLE_LSB +: 8] * r3[`FRG_SEQ_DIV_LSB +: 8]);
    if (wait_load == 16'h0000) begin
      wait_load = 16'h0001;
    end
  end
  // The reserved fourth filter code falls back to the high level.
  assign fg_manual = (r9[`FRG_FG_MAN_LSB +: 2] == 2'h3) ? 2'h2
                   : r9[`FRG_FG_MAN_LSB +: 2];

  // Gain actually applied: ladder under the loop, user fields otherwise.
  assign lna_now = agc_active ? ladder_lna(s_r.gain_idx)
                 : r9[`FRG_STEP_A_LSB +: 2];
  assign fg_now = agc_active ? ladder_fg(s_r.gain_idx) : fg_manual;

  // Readback word: RSSI code, gain codes, calibration and loop status.
  assign readback = {19'h00000, agc_active, s_r.cal_busy, lna_now, fg_now,
                     s_r.rssi};

  // Next-state logic for the whole block.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    // Register file; disabling the chip erases it back to defaults.
    if (!chip_enable) begin
      s_nxt.regs = rst_regs();
    end else if (bus.wr && bus.addr < 4'(`FRG_NUM_REGS)) begin
      s_nxt.regs[bus.addr] = bus.wdata;
      // The start bit is a command and never reads back as set.
      if (bus.addr == 4'h6) begin
        s_nxt.regs[6][`FRG_CAL_START_BIT] = 1'b0;
      end
    end
    // Reads answer one cycle later; unmapped offsets read zero.
    if (bus.rd) begin
      if (bus.addr == `FRG_REG_READBACK) begin
        s_nxt.rdata = readback;
      end else if (bus.addr < 4'(`FRG_NUM_REGS)) begin
        s_nxt.rdata = s_r.regs[bus.addr];
      end
    end
    // Self-timed filter calibration; a repeat start while busy is ignored.
    if (s_r.cal_busy) begin
      if (s_r.cal_cnt == 16'h0000) begin
        s_nxt.cal_busy = 1'b0;
      end else begin
        s_nxt.cal_cnt = s_r.cal_cnt - 16'h0001;
      end
    end else if (chip_enable && bus.wr && bus.addr == 4'h6
                 && bus.wdata[`FRG_CAL_START_BIT]) begin
      s_nxt.cal_busy = 1'b1;
      s_nxt.cal_cnt = 16'(CAL_CYCLES - 1);
    end
    // RSSI digitised each cycle for readback and the gain loop.
    s_nxt.rssi = flash_code(rssi_comparators);
    // Frequency keying follows the data line only while transmitting FSK.
    if (!r0[`FRG_TX_RX_BIT] && r2[`FRG_MOD_SEL_LSB +: 3] == `FRG_MOD_FSK
        && tx_data_line) begin
      s_nxt.divider = 23'(centre + {13'h0000, deviation});
    end else begin
      s_nxt.divider = centre;
    end
    // Offset clock divider; the tap is picked from the divisor code.
    s_nxt.os_cnt = s_r.os_cnt + 4'h1;
    case (r3[`FRG_OS_DIV_LSB +: 2])
      2'h0: s_nxt.os_clk = s_r.os_cnt[1];
      2'h1: s_nxt.os_clk = s_r.os_cnt[2];
      default: s_nxt.os_clk = s_r.os_cnt[3];
    endcase
    // Gain loop: one step per decision, then a settling wait.
    if (!agc_active) begin
      s_nxt.agc = frg_pkg::FRG_AGC_TRACK;
      s_nxt.gain_idx = `FRG_GAIN_TOP;
      s_nxt.wait_cnt = 16'h0000;
    end else begin
      case (s_r.agc)
        frg_pkg::FRG_AGC_TRACK: begin
          if (s_r.rssi < thr_low && s_r.gain_idx < `FRG_GAIN_TOP) begin
            s_nxt.gain_idx = s_r.gain_idx + 3'h1;
            s_nxt.wait_cnt = wait_load;
            s_nxt.agc = frg_pkg::FRG_AGC_SETTLE;
          end else if (s_r.rssi > thr_high && s_r.gain_idx != 3'h0) begin
            s_nxt.gain_idx = s_r.gain_idx - 3'h1;
            s_nxt.wait_cnt = wait_load;
            s_nxt.agc = frg_pkg::FRG_AGC_SETTLE;
          end
        end
        frg_pkg::FRG_AGC_SETTLE: begin
          if (s_r.wait_cnt <= 16'h0001) begin
            s_nxt.wait_cnt = 16'h0000;
            s_nxt.agc = frg_pkg::FRG_AGC_TRACK;
          end else begin
            s_nxt.wait_cnt = s_r.wait_cnt - 16'h0001;
          end
        end
        default: begin
          s_nxt.agc = frg_pkg::FRG_AGC_TRACK;
        end
      endcase
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.regs[2] <= `FRG_RST_R2;
      s_r.regs[3] <= `FRG_RST_R3;
      s_r.regs[9] <= `FRG_RST_R9;
      s_r.regs[10] <= `FRG_RST_R10;
      s_r.gain_idx <= `FRG_GAIN_TOP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs from state flip-flops; the gain step outputs pass through the ladder or user-field decode.
  assign rdata = s_r.rdata;
  assign synth_divider = s_r.divider;
  assign lpf_cal_busy = s_r.cal_busy;
  assign baseband_offset_clock = s_r.os_clk;
  assign rf_ctrl.pa_enable = r2[`FRG_PA_EN_BIT];
  assign rf_ctrl.pa_power = r2[`FRG_PA_PWR_LSB +: 6];
  assign rf_ctrl.pa_bias = r2[`FRG_PA_BIAS_LSB +: 2];
  assign rf_ctrl.mod_select = r2[`FRG_MOD_SEL_LSB +: 3];
  assign rf_ctrl.lna_short_switch = !r0[`FRG_TX_RX_BIT];
  assign rf_ctrl.lna_noise_power_select = r6[`FRG_LNA_NOISE_POWER_SELECT_BIT];
  assign rf_ctrl.mixer_current_linearity_select = r6[`FRG_MIXER_BIT];
  assign rf_ctrl.step_a = lna_now;
  assign rf_ctrl.channel_filter_gain_step = fg_now;
  assign rf_ctrl.lpf_bandwidth = s_r.regs[1][`FRG_LPF_BW_LSB +: 2];
  assign rf_ctrl.lpf_cal_divider = r6[`FRG_CAL_DIV_LSB +: 9];

  // Checks on the behaviour above.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_fsk_key_high: assert property (
    !r0[`FRG_TX_RX_BIT] && r2[8:6] == 3'h0 && tx_data_line && chip_enable
    && !bus.wr |=> synth_divider == $past(centre) + {13'h0, $past(deviation)})
    else $error("deviated divider not applied for data high");

  a_fsk_key_low: assert property (
    !tx_data_line && !bus.wr && chip_enable |=> synth_divider == $past(centre))
    else $error("centre divider not applied for data low");

  a_power_no_data: assert property (
    !bus.wr && chip_enable && $changed(tx_data_line) |=> $stable(rf_ctrl.pa_power))
    else $error("output power moved with the data line");

  a_cal_runs_long: assert property (
    $rose(lpf_cal_busy) |-> lpf_cal_busy [*8])
    else $error("calibration ended too early");

  a_cal_starts: assert property (
    chip_enable && bus.wr && bus.addr == 4'h6 && bus.wdata[19] && !lpf_cal_busy
    |=> lpf_cal_busy && s_r.cal_cnt == 16'(CAL_CYCLES - 1))
    else $error("calibration did not start");

  a_gain_one_step: assert property (
    agc_active && $past(agc_active) && $changed(s_r.gain_idx) |->
    (s_r.gain_idx == $past(s_r.gain_idx) + 3'h1)
    || (s_r.gain_idx + 3'h1 == $past(s_r.gain_idx)))
    else $error("gain moved by more than one step");

  a_gain_settles: assert property (
    agc_active && s_r.agc == frg_pkg::FRG_AGC_TRACK
    && s_nxt.agc == frg_pkg::FRG_AGC_SETTLE
    |=> s_r.wait_cnt == $past(wait_load)
    && s_r.gain_idx != $past(s_r.gain_idx))
    else $error("settle wait not loaded after a gain change");

  a_gain_up_low: assert property (
    agc_active && s_r.agc == frg_pkg::FRG_AGC_TRACK && s_r.rssi < thr_low
    && s_r.gain_idx < 3'h5 && !bus.wr
    |=> s_r.gain_idx == $past(s_r.gain_idx) + 3'h1)
    else $error("gain not raised below the low threshold");

  a_rssi_range: assert property (
    s_r.rssi <= 7'h4f)
    else $error("rssi code above 79");

  a_read_slot: assert property (
    !$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");

endmodule

`default_nettype wire

// *** tb/frg_rssi_src.sv ***
// Flash comparator bank model that feeds the gain control block.
`timescale 1ns/1ps
`default_nettype none
module frg_rssi_src (
  input wire logic [6:0] level,
  output logic [78:0] rssi_comparators
);
  // Tap i trips once the level is above i; 80 levels need 79 taps.
  always_comb begin
    for (int i = 0; i < 79; i++) begin
      rssi_comparators[i] = (7'(i) < level);
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the radio gain control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CAL = 20;
  typedef struct packed {
    logic [3:0] a;
    logic [31:0] w;
    logic [3:0] s;
    logic [8:0] e;
  } frg_row_t;
  logic clock, sys_rst, chip_enable, tx_data_line, os_q;
  frg_pkg::frg_bus_t bus;
  logic [31:0] rdata, d;
  logic [78:0] rssi_comparators;
  logic [22:0] synth_divider;
  frg_pkg::frg_rf_ctrl_t rf_ctrl;
  logic lpf_cal_busy, agc_active, baseband_offset_clock;
  logic [6:0] level;
  logic [3:0] g, g_q;
  logic [3:0] seen[$];
  logic [3:0] lad[6] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'he};
  int st[$];
  int n_mismatch = 0, n_tests = 0, os_cnt = 0, os_per = 0, cyc = 0, n;
  frg_row_t rows[17] = '{
    '{4'h2, 32'h4000_0010, 4'h0, 9'h001},
    '{4'h2, 32'h4000_0000, 4'h0, 9'h000},
    '{4'h2, 32'h0000_7e00, 4'h1, 9'h03f},
    '{4'h2, 32'hc000_0000, 4'h2, 9'h003},
    '{4'h2, 32'h0000_01c0, 4'h3, 9'h007},
    '{4'h0, 32'h0000_0000, 4'h4, 9'h001},
    '{4'h0, 32'h0800_0000, 4'h4, 9'h000},
    '{4'h6, 32'h0000_8000, 4'h5, 9'h001},
    '{4'h6, 32'h0004_0000, 4'h6, 9'h001},
    '{4'h6, 32'h1ff0_0000, 4'ha, 9'h1ff},
    '{4'h1, 32'h0080_0000, 4'h9, 9'h002},
    '{4'h1, 32'h0040_0000, 4'h9, 9'h001},
    '{4'h9, 32'h002c_0000, 4'h7, 9'h002},
    '{4'h9, 32'h00cc_0000, 4'h8, 9'h002},
    '{4'h9, 32'h004c_0000, 4'h8, 9'h001},
    '{4'h9, 32'h0000_0000, 4'hb, 9'h001},
    '{4'h9, 32'h0008_0000, 4'hb, 9'h000}
  };

  frg_gain_control #(.CAL_CYCLES(CAL)) dut_u (.clock(clock),
    .sys_rst(sys_rst), .chip_enable(chip_enable), .bus(bus), .rdata(rdata),
    .tx_data_line(tx_data_line), .rssi_comparators(rssi_comparators),
    .synth_divider(synth_divider), .rf_ctrl(rf_ctrl),
    .lpf_cal_busy(lpf_cal_busy), .agc_active(agc_active),
    .baseband_offset_clock(baseband_offset_clock));
  frg_rssi_src rssi_u (.level(level), .rssi_comparators(rssi_comparators));
  assign g = {rf_ctrl.step_a, rf_ctrl.channel_filter_gain_step};

  // Clock generator, 5 ns period.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Measure the offset clock period and log every gain step with its cycle.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    os_q <= baseband_offset_clock;
    g_q <= g;
    os_cnt <= os_cnt + 1;
    if (baseband_offset_clock === 1'b1 && os_q === 1'b0) begin
      os_per <= os_cnt;
      os_cnt <= 1;
    end
    if (g !== g_q) begin
      seen.push_back(g);
      st.push_back(cyc);
    end
  end

  // Compare one result and count it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, v);
    end
  endtask

  // One-cycle write strobe; a quiet cycle follows so calls never collide.
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    bus <= '{a, w, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so grab them there.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clock);
    #1;
  endtask

  // Drive the data level and look at the divider once it has been loaded.
  task automatic key(input logic b, input logic [22:0] e);
    tx_data_line <= b;
    repeat (2) @(posedge clock);
    #1 chk("divider", 32'(e), 32'(synth_divider));
    chk("power", 32'h0000_000f, 32'(rf_ctrl.pa_power));
  endtask

  function automatic logic [8:0] pick(input logic [3:0] s);
    case (s)
      4'h0: pick = 9'(rf_ctrl.pa_enable);
      4'h1: pick = 9'(rf_ctrl.pa_power);
      4'h2: pick = 9'(rf_ctrl.pa_bias);
      4'h3: pick = 9'(rf_ctrl.mod_select);
      4'h4: pick = 9'(rf_ctrl.lna_short_switch);
      4'h5: pick = 9'(rf_ctrl.lna_noise_power_select);
      4'h6: pick = 9'(rf_ctrl.mixer_current_linearity_select);
      4'h7: pick = 9'(rf_ctrl.step_a);
      4'h8: pick = 9'(rf_ctrl.channel_filter_gain_step);
      4'h9: pick = 9'(rf_ctrl.lpf_bandwidth);
      4'ha: pick = rf_ctrl.lpf_cal_divider;
      default: pick = 9'(agc_active);
    endcase
  endfunction

  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog sized past the roughly 51000 cycles the tests need.
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    close_out();
  end

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    chip_enable = 1'b1;
    tx_data_line = 1'b0;
    level = 7'h00;
    bus = '0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    // Calibrate first after power-up and stay off the bus while it runs.
    wr(4'h6, 32'h0648_0000);
    chk("cal start", 32'h1, 32'(lpf_cal_busy));
    n = 0;
    while (lpf_cal_busy === 1'b1 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    // The write task already let one busy cycle pass before the count.
    chk("cal length", 32'(CAL - 1), 32'(n));
    rd(4'h2, d);
    chk("reg2 reset", 32'h4000_0000, d);
    rd(4'h9, d);
    chk("reg9 reset", 32'h00b2_31e0, d);
    rd(4'ha, d);
    chk("reg10 reset", 32'h0000_00a0, d);
    chk("agc default", 32'h1, 32'(agc_active));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk($sformatf("row %0d", i), 32'(rows[i].e), 32'(pick(rows[i].s)));
    end
    // Keying: full deviation, data low, other scheme, smallest number, rx.
    wr(4'h0, 32'h0123_4400);
    wr(4'h2, 32'h40ff_9e10);
    key(1'b1, 23'h20_1234 + 23'd1022);
    key(1'b0, 23'h20_1234);
    wr(4'h2, 32'h40ff_9e50);
    key(1'b1, 23'h20_1234);
    wr(4'h2, 32'h4000_9e10);
    key(1'b1, 23'h20_1236);
    wr(4'h0, 32'h0923_4400);
    key(1'b1, 23'h20_1234);
    for (int k = 0; k < 4; k++) begin
      wr(4'h3, 32'h0008_0000 | (32'(k) << 4));
      repeat (40) @(posedge clock);
      chk("offset period", 32'(4 << (k > 2 ? 2 : k)), 32'(os_per));
    end
    // Gain loop: settle span 100 x 50 cycles, the 25 us host minimum.
    wr(4'h3, 32'h00c8_0000);
    wr(4'ha, 32'h0000_0640);
    level <= 7'd79;
    seen.delete();
    wr(4'h9, 32'h0002_78f0);
    repeat (100) @(posedge clock);
    level <= 7'd10;
    repeat (100) @(posedge clock);
    chk("steady steps", 32'h1, 32'(seen.size()));
    level <= 7'd79;
    seen.delete();
    st.delete();
    wr(4'h9, 32'h0002_31e0);
    repeat (25200) @(posedge clock);
    for (int i = 0; i < 5; i++) chk("down", 32'(lad[4 - i]), 32'(seen[i]));
    chk("settle", 32'h0000_1389, 32'(st[1] - st[0]));
    rd(4'hf, d);
    chk("readback low", 32'h0000_104f, d);
    level <= 7'd10;
    seen.delete();
    repeat (25200) @(posedge clock);
    for (int i = 0; i < 5; i++) chk("up", 32'(lad[i + 1]), 32'(seen[i]));
    chk("steps", 32'h5, 32'(seen.size()));
    rd(4'hf, d);
    chk("readback high", 32'h0000_170a, d);
    // Unmapped place, then chip enable low restores the defaults.
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, d);
    chk("unmapped", 32'h0, d);
    chip_enable <= 1'b0;
    repeat (2) @(posedge clock);
    chip_enable <= 1'b1;
    @(posedge clock);
    rd(4'h2, d);
    chk("reg2 cleared", 32'h4000_0000, d);
    close_out();
  end
endmodule
`default_nettype wire
